// File: hdl/rxwm_top.sv
// Receive FIFO high-watermark flow control for ports 0 to 2, AXI4-Lite slave.
// Assumes occupancy counts from each port's receive FIFO, in 8-byte units.
//
// What this block does
// - Ports 0..2 each have an independent 12-bit high threshold in bits 11:0.
// - Threshold counts eight-byte FIFO locations.
// - Reset loads every high threshold with 0x0E6, 230 locations.
// - Occupancy above high threshold raises that port's flow-control request.
// - Bits 31:12 read zero, ignore writes; reads clear nothing.
// - Threshold writes are stored and read back, no clearing effects.
// - Occupancy below low threshold drops the flow-control request.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
module rxwm_top
    import rxwm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [RXWM_ADDR_W+1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [RXWM_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [RXWM_ADDR_W+1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [RXWM_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Receive FIFO occupancy, eight-byte units
    input wire logic [RXWM_LVL_W-1:0] rx_level_0,
    input wire logic [RXWM_LVL_W-1:0] rx_level_1,
    input wire logic [RXWM_LVL_W-1:0] rx_level_2,
    // Flow-control requests toward the MAC pause logic
    output logic [RXWM_PORTS-1:0] fc_request
);
    import rxwm_pkg::*;

    typedef struct packed {
        logic aw_full;
        logic [RXWM_ADDR_W-1:0] aw_idx;
        logic w_full;
        logic [RXWM_DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [RXWM_DATA_W-1:0] rdata;
        logic [RXWM_PORTS-1:0][RXWM_THR_W-1:0] hwm;
        logic [RXWM_PORTS-1:0][RXWM_THR_W-1:0] lwm;
        logic [RXWM_PORTS-1:0] fc;
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
    } rxwm_state_t;

    rxwm_state_t st_q;
    rxwm_state_t st_d;
    rxwm_thr_if thr_bus ();

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Word index from a byte address; low two bits ignored
    function automatic logic [RXWM_ADDR_W-1:0] rxwm_idx(input logic [RXWM_ADDR_W+1:0] a);
        return a[RXWM_ADDR_W+1:RXWM_BYTE_SHIFT];
    endfunction : rxwm_idx

    // Byte-lane merge limited to the 12-bit field; upper bits never stored
    function automatic rxwm_thr_t rxwm_merge(input rxwm_thr_t old,
                                             input logic [RXWM_DATA_W-1:0] d,
                                             input logic [3:0] s);
        rxwm_thr_t r;
        r = old;
        if (s[0]) begin
            r[7:0] = d[7:0];
        end
        if (s[1]) begin
            r[RXWM_THR_W-1:8] = d[RXWM_THR_W-1:8];
        end
        return r;
    endfunction : rxwm_merge

    // ------------------------------------------------------------
    // Comparator
    // ------------------------------------------------------------
    always_comb begin
        for (int p = 0; p < RXWM_PORTS; p++) begin
            thr_bus.hwm[p] = st_q.hwm[p];
            thr_bus.lwm[p] = st_q.lwm[p];
        end
        thr_bus.level[0] = rx_level_0;
        thr_bus.level[1] = rx_level_1;
        thr_bus.level[2] = rx_level_2;
    end

    rxwm_flow_ctl rxwm_flow_ctl_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .thr(thr_bus.ctl)
    );

    // ------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------
    always_comb begin
        logic [RXWM_ADDR_W-1:0] ridx;
        logic hit;
        st_d = st_q;
        ridx = rxwm_idx(s_axi_araddr);
        hit = 1'b0;
        st_d.fc = thr_bus.pause;

        // Capture address and data independently, in either order
        if (s_axi_awvalid && st_q.aw_rdy) begin
            st_d.aw_full = 1'b1;
            st_d.aw_idx = rxwm_idx(s_axi_awaddr);
        end
        if (s_axi_wvalid && st_q.w_rdy) begin
            st_d.w_full = 1'b1;
            st_d.wdata = s_axi_wdata;
            st_d.wstrb = s_axi_wstrb;
        end

        if (st_q.aw_full && st_q.w_full && !st_q.bvalid) begin
            st_d.aw_full = 1'b0;
            st_d.w_full = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = RXWM_RESP_OKAY;
            unique case (st_q.aw_idx)
                RXWM_IDX_HWM0: st_d.hwm[0] = rxwm_merge(st_q.hwm[0], st_q.wdata, st_q.wstrb);
                RXWM_IDX_HWM1: st_d.hwm[1] = rxwm_merge(st_q.hwm[1], st_q.wdata, st_q.wstrb);
                RXWM_IDX_HWM2: st_d.hwm[2] = rxwm_merge(st_q.hwm[2], st_q.wdata, st_q.wstrb);
                RXWM_IDX_LWM0: st_d.lwm[0] = rxwm_merge(st_q.lwm[0], st_q.wdata, st_q.wstrb);
                RXWM_IDX_LWM1: st_d.lwm[1] = rxwm_merge(st_q.lwm[1], st_q.wdata, st_q.wstrb);
                RXWM_IDX_LWM2: st_d.lwm[2] = rxwm_merge(st_q.lwm[2], st_q.wdata, st_q.wstrb);
                RXWM_IDX_STAT: st_d.bresp = RXWM_RESP_OKAY;
                default: st_d.bresp = RXWM_RESP_SLVERR;
            endcase
        end else if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end

        // Reads have no side effects on any register
        if (st_q.rvalid) begin
            if (s_axi_rready) begin
                st_d.rvalid = 1'b0;
            end
        end else if (s_axi_arvalid && st_q.ar_rdy) begin
            st_d.rvalid = 1'b1;
            st_d.rdata = '0;
            hit = 1'b1;
            unique case (ridx)
                RXWM_IDX_HWM0: st_d.rdata[RXWM_THR_W-1:0] = st_q.hwm[0];
                RXWM_IDX_HWM1: st_d.rdata[RXWM_THR_W-1:0] = st_q.hwm[1];
                RXWM_IDX_HWM2: st_d.rdata[RXWM_THR_W-1:0] = st_q.hwm[2];
                RXWM_IDX_LWM0: st_d.rdata[RXWM_THR_W-1:0] = st_q.lwm[0];
                RXWM_IDX_LWM1: st_d.rdata[RXWM_THR_W-1:0] = st_q.lwm[1];
                RXWM_IDX_LWM2: st_d.rdata[RXWM_THR_W-1:0] = st_q.lwm[2];
                RXWM_IDX_STAT: st_d.rdata[RXWM_PORTS-1:0] = st_q.fc;
                default: hit = 1'b0;
            endcase
            st_d.rresp = hit ? RXWM_RESP_OKAY : RXWM_RESP_SLVERR;
        end

        // Readies follow the next state, so they stay low through reset
        st_d.aw_rdy = !st_d.aw_full && !st_d.bvalid;
        st_d.w_rdy = !st_d.w_full && !st_d.bvalid;
        st_d.ar_rdy = !st_d.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
            for (int p = 0; p < RXWM_PORTS; p++) begin
                st_q.hwm[p] <= RXWM_HWM_RST;
                st_q.lwm[p] <= RXWM_LWM_RST;
            end
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Ready lines are flops, so a request is never taken while they read low
    assign s_axi_awready = st_q.aw_rdy;
    assign s_axi_wready = st_q.w_rdy;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = st_q.ar_rdy;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rresp = st_q.rresp;
    assign s_axi_rdata = st_q.rdata;
    assign fc_request = st_q.fc;

endmodule : rxwm_top

// File: shared/rxwm_pkg.sv
// Package for the receive FIFO high-watermark flow-control block.
// Assumes a 32-bit AXI4-Lite register bus and a single 100 MHz clock.
package rxwm_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int RXWM_PORTS = 3;
    localparam int RXWM_THR_W = 12;
    localparam int RXWM_LVL_W = 12;
    localparam int RXWM_ADDR_W = 12;
    localparam int RXWM_DATA_W = 32;
    localparam int RXWM_UNIT_BYTES = 8;

    // ------------------------------------------------------------
    // Register map: printed offsets are word indices
    // ------------------------------------------------------------
    localparam logic [RXWM_ADDR_W-1:0] RXWM_IDX_HWM0 = 12'h580;
    localparam logic [RXWM_ADDR_W-1:0] RXWM_IDX_HWM1 = 12'h581;
    localparam logic [RXWM_ADDR_W-1:0] RXWM_IDX_HWM2 = 12'h582;
    localparam logic [RXWM_ADDR_W-1:0] RXWM_IDX_LWM0 = 12'h58A;
    localparam logic [RXWM_ADDR_W-1:0] RXWM_IDX_LWM1 = 12'h58B;
    localparam logic [RXWM_ADDR_W-1:0] RXWM_IDX_LWM2 = 12'h58C;
    localparam logic [RXWM_ADDR_W-1:0] RXWM_IDX_STAT = 12'h590;
    localparam int RXWM_BYTE_SHIFT = 2;

    // ------------------------------------------------------------
    // Reset values and responses
    // ------------------------------------------------------------
    localparam logic [RXWM_THR_W-1:0] RXWM_HWM_RST = 12'h0E6;
    localparam logic [RXWM_THR_W-1:0] RXWM_LWM_RST = 12'h072;
    localparam logic [1:0] RXWM_RESP_OKAY = 2'h0;
    localparam logic [1:0] RXWM_RESP_SLVERR = 2'h2;

    typedef logic [RXWM_THR_W-1:0] rxwm_thr_t;
    typedef logic [RXWM_LVL_W-1:0] rxwm_lvl_t;

endpackage : rxwm_pkg

// File: shared/rxwm_thr_if.sv
// Interface carrying thresholds and occupancy to the flow-control comparator.
// Assumes one clock; all signals are synchronous levels.
`timescale 1ns/1ns
interface rxwm_thr_if;
    import rxwm_pkg::*;
    rxwm_thr_t hwm [RXWM_PORTS];
    rxwm_thr_t lwm [RXWM_PORTS];
    rxwm_lvl_t level [RXWM_PORTS];
    logic [RXWM_PORTS-1:0] pause;

    modport regs (output hwm, output lwm, output level, input pause);
    modport ctl (input hwm, input lwm, input level, output pause);
endinterface : rxwm_thr_if

// File: hdl/rxwm_flow_ctl.sv
// Per-port hysteresis comparator driving the flow-control requests.
// Assumes occupancy in eight-byte units, synchronous to aclk.
`timescale 1ns/1ns
module rxwm_flow_ctl
    import rxwm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Thresholds in, requests out
    rxwm_thr_if.ctl thr
);

    typedef struct packed {
        logic [RXWM_PORTS-1:0] pause;
    } rxwm_fc_state_t;

    rxwm_fc_state_t st_q;
    rxwm_fc_state_t st_d;

    always_comb begin
        st_d = st_q;
        for (int p = 0; p < RXWM_PORTS; p++) begin
            // Level and threshold share the eight-byte unit, so no scaling
            if (thr.level[p] > thr.hwm[p]) begin
                st_d.pause[p] = 1'b1;
            end else if (thr.level[p] < thr.lwm[p]) begin
                st_d.pause[p] = 1'b0;
            end
            // Between thresholds the request keeps its value
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign thr.pause = st_q.pause;

endmodule : rxwm_flow_ctl

// File: testbench/rxwm_asserts.sv
// Checker for the receive watermark block, bound to its top module.
// Assumes default thresholds hold until the first write after each reset.
`timescale 1ns/1ns
module rxwm_asserts (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rxwm_pkg::RXWM_DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Occupancy and requests
    input wire logic [rxwm_pkg::RXWM_LVL_W-1:0] rx_level_0,
    input wire logic [rxwm_pkg::RXWM_LVL_W-1:0] rx_level_1,
    input wire logic [rxwm_pkg::RXWM_LVL_W-1:0] rx_level_2,
    input wire logic [rxwm_pkg::RXWM_PORTS-1:0] fc_request
);
    import rxwm_pkg::*;
    logic wr_q;
    // Any write may move a threshold, so the default-based checks stop there
    always_ff @(posedge aclk) wr_q <= aresetn && (wr_q || (s_axi_awvalid && s_axi_awready));
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_over0; !wr_q && rx_level_0 > RXWM_HWM_RST; endsequence
    sequence s_under0; !wr_q && rx_level_0 < RXWM_LWM_RST; endsequence
    property p_set0; s_over0 |-> ##2 fc_request[0]; endproperty
    property p_set1; !wr_q && rx_level_1 > RXWM_HWM_RST |-> ##2 fc_request[1]; endproperty
    property p_set2; !wr_q && rx_level_2 > 12'h0E6 |-> ##2 fc_request[2]; endproperty
    property p_clr0; s_under0 |-> ##2 !fc_request[0]; endproperty
    property p_hold0;
        fc_request[0] && !wr_q && $past(rx_level_0) >= RXWM_LWM_RST |=> fc_request[0];
    endproperty
    property p_rsvd; s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h0; endproperty
    property p_bonce; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    property p_ronce; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_set0: assert property (p_set0) else $error("port 0 request late");
    a_set1: assert property (p_set1) else $error("port 1 request late");
    a_set2: assert property (p_set2) else $error("port 2 request late");
    a_clr0: assert property (p_clr0) else $error("port 0 request stuck");
    a_hold0: assert property (p_hold0) else $error("port 0 request dropped");
    a_rsvd: assert property (p_rsvd) else $error("upper read bits set");
    a_bonce: assert property (p_bonce) else $error("extra write response");
    a_ronce: assert property (p_ronce) else $error("extra read response");
endmodule : rxwm_asserts

// File: testbench/rxwm_tb_top.sv
// Testbench for the receive watermark block: register and flow scenarios.
// Assumes the package, the design and the checker are compiled first.
`timescale 1ns/1ns
module rxwm_tb_top;
    import rxwm_pkg::*;
    logic aclk = '0;
    logic aresetn = '0;
    logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [11:0] rx_level_0 = '0, rx_level_1 = '0, rx_level_2 = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [2:0] fc_request;
    int n_fail = 0, checks_done = 0, cyc = 0;
    always #5 aclk = ~aclk;
    rxwm_top rxwm_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_level_0, .rx_level_1, .rx_level_2,
        .fc_request);
    // --------------------------------------------------------
    // Bus and compare tasks
    // --------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= d;
        s_axi_awvalid <= '1;
        s_axi_wvalid <= '1;
        s_axi_bready <= '1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= '0;
            if (s_axi_wready) s_axi_wvalid <= '0;
        end while (!s_axi_bvalid);
        s_axi_bready <= '0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        // One idle edge so a following call never re-raises in the same step
        @(posedge aclk);
    endtask : wr
    task automatic rdc(input logic [11:0] idx, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= '1;
        s_axi_rready <= '1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= '0;
        end while (!s_axi_rvalid);
        s_axi_rready <= '0;
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge aclk);
    endtask : rdc
    // Request is registered twice, so three edges cover the latency
    task automatic lvl(input logic [11:0] a, b, c, input logic [2:0] exp);
        rx_level_0 <= a;
        rx_level_1 <= b;
        rx_level_2 <= c;
        repeat (3) @(posedge aclk);
        chk({29'h0, fc_request}, {29'h0, exp});
    endtask : lvl
    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    task automatic t_defaults;
        for (int i = 0; i < 3; i++) rdc(RXWM_IDX_HWM0 + 12'(i), 32'h0E6, RXWM_RESP_OKAY);
        rdc(RXWM_IDX_HWM0, 32'h0E6, RXWM_RESP_OKAY);
        rdc(RXWM_IDX_LWM0, 32'h072, RXWM_RESP_OKAY);
        $display("done defaults");
    endtask : t_defaults
    task automatic t_hyst;
        lvl(12'h0E6, 12'h0E7, 12'h0E6, 3'h2);
        lvl(12'h0E7, 12'h0E7, 12'h0E7, 3'h7);
        rdc(RXWM_IDX_STAT, 32'h7, RXWM_RESP_OKAY);
        lvl(12'h072, 12'h072, 12'h072, 3'h7);
        lvl(12'h071, 12'h072, 12'h072, 3'h6);
        lvl(12'h000, 12'h000, 12'h000, 3'h0);
        $display("done hysteresis");
    endtask : t_hyst
    task automatic t_write;
        // New highs stay above the default lows
        for (int i = 0; i < 3; i++) wr(RXWM_IDX_HWM0 + 12'(i), 32'hFFFFF100 + 32'(i), 2'h0);
        for (int i = 0; i < 3; i++) rdc(RXWM_IDX_HWM0 + 12'(i), 32'h100 + 32'(i), 2'h0);
        lvl(12'h100, 12'h101, 12'h000, 3'h0);
        lvl(12'h101, 12'h101, 12'h000, 3'h1);
        lvl(12'h000, 12'h000, 12'h000, 3'h0);
        $display("done write");
    endtask : t_write
    task automatic t_unmapped;
        wr(12'h5A0, 32'h00000ABC, RXWM_RESP_SLVERR);
        rdc(12'h5A0, 32'h0, RXWM_RESP_SLVERR);
        $display("done unmapped");
    endtask : t_unmapped
    task automatic t_lanes;
        // Only lane 1 enabled: bits 11:8 change, bits 7:0 keep the reset value
        s_axi_wstrb <= 4'h2;
        wr(RXWM_IDX_LWM0, 32'h00000A55, RXWM_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rdc(RXWM_IDX_LWM0, 32'h00000A72, RXWM_RESP_OKAY);
        wr(RXWM_IDX_STAT, 32'h00000007, RXWM_RESP_OKAY);
        rdc(RXWM_IDX_STAT, 32'h0, RXWM_RESP_OKAY);
        $display("done lanes");
    endtask : t_lanes
    task automatic t_rereset;
        aresetn <= '0;
        repeat (4) @(posedge aclk);
        aresetn <= '1;
        repeat (2) @(posedge aclk);
        rdc(RXWM_IDX_HWM1, 32'h0E6, RXWM_RESP_OKAY);
        $display("done rereset");
    endtask : t_rereset
    task automatic give_verdict;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= '1;
        repeat (2) @(posedge aclk);
        t_defaults();
        t_hyst();
        t_write();
        t_unmapped();
        t_lanes();
        t_rereset();
        give_verdict();
    end
endmodule : rxwm_tb_top
bind rxwm_top rxwm_asserts rxwm_asserts_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .rx_level_0, .rx_level_1, .rx_level_2, .fc_request);
